// File: inc/dacwl_defines.vh
// constants for the dac register write lock block
//
// Overview of operation
// R01: two nonvolatile lock bits per channel
// R02: both set: value and configuration fully locked
// R03: value lock only: volatile configuration stays writable
// R04: config lock only: volatile writable, nonvolatile locked
// R05: both clear: everything writable
// R06: lock bits change only under high voltage
// R07: 00h config lock, 10h value lock
// R08: bad command nacked, recover on start
// R09: lock bits survive power-on reset
// R10: reset copies nonvolatile values into volatile
// R11: bus address kept in nonvolatile memory
// R12: address lock set freezes address bits
// R13: address lock changed only at 1Ah
// R14: configuration is reference, power-down, gain
// R15: lock bits mirrored into status register
// R16: output code right-justified, upper bits zero
// R17: full, mid and zero scale codes
// R18: reference field two bits per channel
// R19: high voltage to unimplemented bit nacked
// R20: reserved address nacked, reads all ones
// R21: protected write leaves contents unchanged
`ifndef DACWL_DEFINES_VH
`define DACWL_DEFINES_VH

// register addresses
`define DACWL_A_DAC0 5'h00
`define DACWL_A_DAC1 5'h01
`define DACWL_A_VREF 5'h08
`define DACWL_A_PD 5'h09
`define DACWL_A_GAIN 5'h0a
`define DACWL_A_WLST 5'h0b
`define DACWL_A_NV_DAC0 5'h10
`define DACWL_A_NV_DAC1 5'h11
`define DACWL_A_NV_VREF 5'h18
`define DACWL_A_NV_PD 5'h19
`define DACWL_A_NV_GAIN 5'h1a

// nonvolatile word index: {addr[3], addr[1:0]}
`define DACWL_I_DAC0 3'h0
`define DACWL_I_DAC1 3'h1
`define DACWL_I_VREF 3'h4
`define DACWL_I_PD 3'h5
`define DACWL_I_GAIN 3'h6

// command opcodes
`define DACWL_OP_WR 2'h0
`define DACWL_OP_RD 2'h1
`define DACWL_OP_EN 2'h2
`define DACWL_OP_DIS 2'h3

// field positions
`define DACWL_GAIN_LSB 8
`define DACWL_POR_BIT 7
`define DACWL_BUS_ADDR_LOCK_BIT_BIT 7

// reset and default values
`define DACWL_RES_DEF 12
`define DACWL_NCH_DEF 2
`define DACWL_FACT_ADDR 16'h0060
`define DACWL_FACT_BUS_ADDR_LOCK_BIT 1'b1
`define DACWL_RESERVED_RD 16'hffff
`define DACWL_BOOT_LAST 3'h4

`endif

// File: rtl/dacwl_nvmem.v
// nonvolatile word store with registered read
`timescale 1ns/10ps
`include "dacwl_defines.vh"
module dacwl_nvmem #(
	parameter AW = 3,
	parameter DW = 16,
	parameter [15:0] MID = 16'h07ff
) (
	input wire clock,
	input wire factory_init,
	input wire wr_en,
	input wire [AW-1:0] wr_idx,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_idx,
	output reg [DW-1:0] rd_q
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	integer i;

	// factory contents: mid-scale codes, default bus address
	function [DW-1:0] init_word;
		input integer n;
		begin
			if (n < 2)
				init_word = MID[DW-1:0];
			else if (n == `DACWL_I_GAIN)
				init_word = `DACWL_FACT_ADDR;
			else
				init_word = {DW{1'b0}};
		end
	endfunction

	always @(posedge clock) begin
		if (factory_init) begin
			for (i = 0; i < (1 << AW); i = i + 1) begin
				mem[i] <= init_word(i);
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		rd_q <= mem[rd_idx];
	end
endmodule // dacwl_nvmem

// File: rtl/dacwl_lock.v
// dac register set with lock-mode write protection
`timescale 1ns/10ps
`include "dacwl_defines.vh"
module dacwl_lock #(
	parameter NUM_CH = `DACWL_NCH_DEF,
	parameter RES = `DACWL_RES_DEF
) (
	input wire clock,
	input wire srst,
	input wire factory_init,
	input wire high_voltage_cmd_pin,
	input wire start_seen,
	input wire cmd_valid,
	input wire [1:0] cmd_op,
	input wire [4:0] cmd_addr,
	input wire [15:0] cmd_wdata,
	output reg cmd_ready,
	output reg cmd_done,
	output reg cmd_ack,
	output reg [15:0] rd_data,
	output reg wait_start,
	output reg [15:0] dac0_code,
	output reg [15:0] dac1_code,
	output reg [3:0] ref_select_bits,
	output reg [3:0] powerdown_bits,
	output reg [1:0] output_gain_bit,
	output reg [6:0] stored_bus_addr_bits,
	output reg [1:0] value_lock_bit,
	output reg [1:0] config_lock_bit,
	output reg bus_addr_lock_bit
);
	localparam [15:0] CODE_MASK = ~(16'hffff << RES); // see R16
	localparam [1:0] CH_MASK = (NUM_CH == 2) ? 2'h3 : 2'h1;
	// implemented reference and power-down bits
	localparam [3:0] CFG_FULL = {{2{CH_MASK[1]}}, {2{CH_MASK[0]}}}; // see R18

	localparam [4:0] ST_BOOTA = 5'b00001;
	localparam [4:0] ST_BOOTB = 5'b00010;
	localparam [4:0] ST_IDLE = 5'b00100;
	localparam [4:0] ST_NVRD = 5'b01000;
	localparam [4:0] ST_NVDO = 5'b10000;

	reg [4:0] state;
	reg [2:0] boot_cnt;
	reg [2:0] pend_idx;
	reg pend_wr;
	reg [15:0] pend_data;
	reg por_flag;
	reg hv_meta;
	reg hv_sync;
	wire [15:0] nv_q;

	// decode results
	reg ch;
	reg is_vdac;
	reg is_nvdac;
	reg is_vcfg;
	reg is_wlst;
	reg is_nvcfg;
	reg acc;
	reg [1:0] next_value_lock;
	reg [1:0] next_config_lock;
	reg next_addr_lock;
	reg [1:0] vdac_lk;
	reg [1:0] nvdac_lk;
	reg [1:0] vcfg_ok;
	reg [1:0] nvcfg_ok;
	reg [15:0] vref_w;
	reg [15:0] pd_w;
	reg [15:0] gain_w;
	reg [15:0] nv_wdata;
	reg [15:0] vol_view;
	reg [15:0] nv_view;
	wire take;
	wire [2:0] cmd_idx;
	wire hv_op;

	assign take = cmd_valid & cmd_ready;
	assign cmd_idx = {cmd_addr[3], cmd_addr[1:0]};
	assign hv_op = cmd_op[1];

	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [15:0] mask;
		begin
			merge = (old & ~mask) | (nw & mask);
		end
	endfunction

	// two bits per channel for reference and power-down fields
	function [15:0] cfg_mask;
		input [1:0] m;
		begin
			cfg_mask = {12'h000, {2{m[1]}}, {2{m[0]}}}; // see R18
		end
	endfunction

	function [2:0] boot_index;
		input [2:0] n;
		begin
			boot_index = (n < 3'h2) ? n : n + 3'h2;
		end
	endfunction

	// high voltage pin comes from outside
	always @(posedge clock) begin
		if (srst) begin
			hv_meta <= 1'b0;
			hv_sync <= 1'b0;
		end else begin
			hv_meta <= high_voltage_cmd_pin;
			hv_sync <= hv_meta;
		end
	end

	always @* begin
		ch = cmd_addr[0];
		is_vdac = (cmd_addr[4:1] == 4'h0) && (!ch || NUM_CH == 2);
		is_nvdac = (cmd_addr[4:1] == 4'h8) && (!ch || NUM_CH == 2);
		is_vcfg = (cmd_addr == `DACWL_A_VREF) ||
			(cmd_addr == `DACWL_A_PD) || (cmd_addr == `DACWL_A_GAIN);
		is_wlst = (cmd_addr == `DACWL_A_WLST);
		is_nvcfg = (cmd_addr == `DACWL_A_NV_VREF) ||
			(cmd_addr == `DACWL_A_NV_PD) ||
			(cmd_addr == `DACWL_A_NV_GAIN);
		// lock modes per channel
		vdac_lk = value_lock_bit; // see R03
		nvdac_lk = value_lock_bit | config_lock_bit; // see R04
		vcfg_ok = CH_MASK & ~(value_lock_bit & config_lock_bit); // see R02
		nvcfg_ok = CH_MASK & ~(value_lock_bit | config_lock_bit); // see R05
		next_value_lock = value_lock_bit;
		next_config_lock = config_lock_bit;
		next_addr_lock = bus_addr_lock_bit;
		acc = 1'b0;
		case (cmd_op)
		`DACWL_OP_RD: begin
			acc = is_vdac | is_nvdac | is_vcfg | is_wlst | is_nvcfg; // see R20
		end
		`DACWL_OP_WR: begin
			if (is_vdac)
				acc = ~vdac_lk[ch]; // see R21
			else if (is_vcfg)
				acc = |vcfg_ok; // see R14
			else if (is_nvdac)
				acc = ~nvdac_lk[ch]; // see R21
			else if (cmd_addr == `DACWL_A_NV_GAIN)
				acc = (|nvcfg_ok) | ~bus_addr_lock_bit; // see R12
			else if (is_nvcfg)
				acc = |nvcfg_ok;
		end
		default: begin
			// enable sets, disable clears; needs elevated level
			if (hv_sync && !wait_start) begin // see R06
				if (is_vdac) begin
					next_config_lock[ch] = ~cmd_op[0]; // see R07
					acc = 1'b1;
				end else if (is_nvdac) begin
					next_value_lock[ch] = ~cmd_op[0]; // see R07
					acc = 1'b1;
				end else if (cmd_addr == `DACWL_A_NV_GAIN) begin
					next_addr_lock = ~cmd_op[0]; // see R13
					acc = 1'b1;
				end
			end
		end
		endcase
		if (wait_start)
			acc = 1'b0; // see R08
		vref_w = merge({12'h000, ref_select_bits}, cmd_wdata,
			cfg_mask(vcfg_ok));
		pd_w = merge({12'h000, powerdown_bits}, cmd_wdata,
			cfg_mask(vcfg_ok));
		gain_w = merge({14'h0000, output_gain_bit}, {14'h0000,
			cmd_wdata[9:8]}, {14'h0000, vcfg_ok});
		// nonvolatile read-modify-write
		case (pend_idx)
		`DACWL_I_DAC0, `DACWL_I_DAC1: nv_wdata = pend_data & CODE_MASK;
		`DACWL_I_GAIN: nv_wdata = merge(nv_q, pend_data,
			{6'h00, nvcfg_ok, 1'b0,
			{7{~bus_addr_lock_bit}}}); // see R12
		default: nv_wdata = merge(nv_q, pend_data, cfg_mask(nvcfg_ok));
		endcase
		case (cmd_addr)
		`DACWL_A_DAC0: vol_view = dac0_code;
		`DACWL_A_DAC1: vol_view = dac1_code;
		`DACWL_A_VREF: vol_view = {12'h000, ref_select_bits};
		`DACWL_A_PD: vol_view = {12'h000, powerdown_bits};
		`DACWL_A_GAIN: vol_view = {6'h00, output_gain_bit, por_flag, 7'h00};
		// status mirrors {dl1, cl1, dl0, cl0}
		`DACWL_A_WLST: vol_view = {12'h000, value_lock_bit[1],
			config_lock_bit[1], value_lock_bit[0],
			config_lock_bit[0]}; // see R15
		default: vol_view = `DACWL_RESERVED_RD;
		endcase
		case (pend_idx)
		`DACWL_I_DAC0, `DACWL_I_DAC1: nv_view = nv_q & CODE_MASK;
		`DACWL_I_GAIN: nv_view = {6'h00, nv_q[9:8] & CH_MASK,
			bus_addr_lock_bit, nv_q[6:0]};
		default: nv_view = nv_q & cfg_mask(CH_MASK);
		endcase
	end

	// lock bits are nonvolatile: system reset leaves them alone
	always @(posedge clock) begin
		if (factory_init) begin
			value_lock_bit <= 2'h0; // see R01
			config_lock_bit <= 2'h0;
			bus_addr_lock_bit <= `DACWL_FACT_BUS_ADDR_LOCK_BIT;
		end else if (!srst && take && acc && hv_op) begin // see R09
			value_lock_bit <= next_value_lock;
			config_lock_bit <= next_config_lock;
			bus_addr_lock_bit <= next_addr_lock;
		end
	end

	dacwl_nvmem #(
		.AW(3),
		.DW(16),
		.MID(CODE_MASK >> 1)
	) u_nvmem (
		.clock(clock),
		.factory_init(factory_init),
		.wr_en(state == ST_NVDO && pend_wr),
		.wr_idx(pend_idx),
		.wr_data(nv_wdata),
		.rd_idx(pend_idx),
		.rd_q(nv_q)
	);

	always @(posedge clock) begin
		if (srst) begin
			state <= ST_BOOTA;
			boot_cnt <= 3'h0;
			pend_idx <= `DACWL_I_DAC0;
			pend_wr <= 1'b0;
			pend_data <= 16'h0000;
			cmd_ready <= 1'b0;
			cmd_done <= 1'b0;
			cmd_ack <= 1'b0;
			rd_data <= 16'h0000;
			wait_start <= 1'b0;
			por_flag <= 1'b1;
			dac0_code <= 16'h0000;
			dac1_code <= 16'h0000;
			ref_select_bits <= 4'h0;
			powerdown_bits <= 4'h0;
			output_gain_bit <= 2'h0;
			stored_bus_addr_bits <= 7'h00;
		end else begin
			cmd_done <= 1'b0;
			cmd_ack <= 1'b0;
			if (start_seen)
				wait_start <= 1'b0; // see R08
			case (state)
			ST_BOOTA: begin
				state <= ST_BOOTB;
			end
			ST_BOOTB: begin
				// reload volatile copies from nonvolatile ones
				case (boot_cnt)
				3'h0: dac0_code <= nv_q & CODE_MASK; // see R10
				3'h1: begin
					if (NUM_CH == 2)
						dac1_code <= nv_q & CODE_MASK; // see R10
				end
				3'h2: ref_select_bits <= nv_q[3:0] & CFG_FULL;
				3'h3: powerdown_bits <= nv_q[3:0] & CFG_FULL;
				default: begin
					output_gain_bit <= nv_q[9:8] & CH_MASK;
					stored_bus_addr_bits <= nv_q[6:0]; // see R11
				end
				endcase
				if (boot_cnt == `DACWL_BOOT_LAST) begin
					state <= ST_IDLE;
					cmd_ready <= 1'b1;
				end else begin
					boot_cnt <= boot_cnt + 3'h1;
					pend_idx <= boot_index(boot_cnt + 3'h1);
					state <= ST_BOOTA;
				end
			end
			ST_IDLE: begin
				if (take) begin
					if (!acc) begin
						// refused: nack, hold off until a new start
						cmd_done <= 1'b1;
						rd_data <= `DACWL_RESERVED_RD; // see R20
						wait_start <= 1'b1; // see R19
					end else if (!hv_op && (is_nvdac || is_nvcfg)) begin
						pend_idx <= cmd_idx;
						pend_wr <= (cmd_op == `DACWL_OP_WR);
						pend_data <= cmd_wdata;
						cmd_ready <= 1'b0;
						state <= ST_NVRD;
					end else begin
						cmd_done <= 1'b1;
						cmd_ack <= 1'b1;
						rd_data <= (cmd_op == `DACWL_OP_RD) ? vol_view :
							16'h0000;
						if (cmd_op == `DACWL_OP_WR) begin
							if (is_vdac && ch)
								dac1_code <= cmd_wdata & CODE_MASK; // see R16
							else if (is_vdac)
								dac0_code <= cmd_wdata & CODE_MASK; // see R17
							else if (cmd_addr == `DACWL_A_VREF)
								ref_select_bits <= vref_w[3:0]; // see R21
							else if (cmd_addr == `DACWL_A_PD)
								powerdown_bits <= pd_w[3:0]; // see R21
							else begin
								output_gain_bit <= gain_w[1:0]; // see R21
								if (!cmd_wdata[`DACWL_POR_BIT])
									por_flag <= 1'b0;
							end
						end
					end
				end
			end
			ST_NVRD: begin
				state <= ST_NVDO;
			end
			ST_NVDO: begin
				cmd_done <= 1'b1;
				cmd_ack <= 1'b1;
				rd_data <= pend_wr ? 16'h0000 : nv_view;
				cmd_ready <= 1'b1;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
				cmd_ready <= 1'b1;
			end
			endcase
		end
	end
endmodule // dacwl_lock

// File: tb/dacwl_chk.sv
// assertions on the lock block command port and lock outputs
`timescale 1ns/10ps
module dacwl_chk #(
	parameter NUM_CH = 2,
	parameter RES = 12
) (
	input wire clock,
	input wire srst,
	input wire factory_init,
	input wire high_voltage_cmd_pin,
	input wire start_seen,
	input wire cmd_valid,
	input wire [1:0] cmd_op,
	input wire [4:0] cmd_addr,
	input wire [15:0] cmd_wdata,
	input wire cmd_ready,
	input wire cmd_done,
	input wire cmd_ack,
	input wire [15:0] rd_data,
	input wire wait_start,
	input wire [15:0] dac0_code,
	input wire [1:0] value_lock_bit,
	input wire [1:0] config_lock_bit,
	input wire bus_addr_lock_bit
);
localparam [15:0] MASK = (16'h1 << RES) - 16'h1;
wire take = cmd_valid && cmd_ready;
wire wr0 = take && cmd_op == 2'h0 && cmd_addr == 5'h00;
wire [4:0] locks = {value_lock_bit, config_lock_bit, bus_addr_lock_bit};
default clocking cb @(posedge clock);
endclocking
default disable iff (srst);
sequence s_nack;
	cmd_done && !cmd_ack;
endsequence
sequence s_pin_low_take;
	!high_voltage_cmd_pin [*3] ##0 take && cmd_op[1];
endsequence
property p_nack_ones;
	s_nack |-> rd_data == 16'hffff;
endproperty
a_nack_ones: assert property (p_nack_ones)
	else $error("nack without all-ones data");
property p_nack_wait;
	s_nack |-> wait_start ##1 (wait_start || $past(start_seen));
endproperty
a_nack_wait: assert property (p_nack_wait)
	else $error("nack did not hold off commands");
property p_wait_refuse;
	wait_start && take && !start_seen |=> s_nack;
endproperty
a_wait_refuse: assert property (p_wait_refuse)
	else $error("command taken while waiting for start");
property p_hv_pin;
	s_pin_low_take |=> s_nack;
endproperty
a_hv_pin: assert property (p_hv_pin)
	else $error("lock command accepted without high voltage");
property p_lock_hv;
	$changed(locks) && !$past(factory_init) |-> cmd_done && cmd_ack;
endproperty
a_lock_hv: assert property (p_lock_hv)
	else $error("lock bit moved without a command");
property p_lock_por;
	@(posedge clock) disable iff (1'b0)
	srst && !factory_init |=> $stable(locks);
endproperty
a_lock_por: assert property (p_lock_por)
	else $error("lock bit moved by reset");
property p_vol_locked;
	wr0 && value_lock_bit[0] |=> s_nack ##0 $stable(dac0_code);
endproperty
a_vol_locked: assert property (p_vol_locked)
	else $error("locked output value was written");
property p_vol_free;
	wr0 && !value_lock_bit[0] && !wait_start
		|=> cmd_ack && dac0_code == ($past(cmd_wdata) & MASK);
endproperty
a_vol_free: assert property (p_vol_free)
	else $error("unlocked output value not written");
endmodule // dacwl_chk
bind dacwl_lock dacwl_chk #(.NUM_CH(NUM_CH), .RES(RES)) dacwl_chk_i (
	.clock, .srst, .factory_init, .high_voltage_cmd_pin, .start_seen,
	.cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .cmd_done,
	.cmd_ack, .rd_data, .wait_start, .dac0_code, .value_lock_bit,
	.config_lock_bit, .bus_addr_lock_bit);

// File: tb/dacwl_host.sv
// bus master model issuing normal and high-voltage commands
`timescale 1ns/10ps
module dacwl_host (
	input wire logic clock,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic cmd_ack,
	input wire logic [15:0] rd_data,
	output logic high_voltage_cmd_pin = 1'b0,
	output logic start_seen = 1'b0,
	output logic cmd_valid = 1'b0,
	output logic [1:0] cmd_op = 2'h0,
	output logic [4:0] cmd_addr = 5'h00,
	output logic [15:0] cmd_wdata = 16'h0000
);
logic slow = 1'b0;
task automatic cmd(input logic h, input logic [1:0] o,
	input logic [4:0] a, input logic [15:0] w, output logic k,
	output logic [15:0] q, output logic ok);
	int i;
	logic t;
	t = 1'b0;
	ok = 1'b0;
	if (h)
		high_voltage_cmd_pin = 1'b1;
	if (h || slow) begin
		repeat (3) @(posedge clock);
		#1;
	end
	cmd_op = o;
	cmd_addr = a;
	cmd_wdata = w;
	cmd_valid = 1'b1;
	for (i = 0; i < 20 && !t; i++) begin
		@(posedge clock);
		t = cmd_ready;
	end
	#1;
	// released lines show the inverse, not the old value
	cmd_valid = 1'b0;
	cmd_op = ~o;
	cmd_addr = ~a;
	cmd_wdata = ~w;
	for (i = 0; i < 20 && t && !ok; i++) begin
		@(posedge clock);
		ok = cmd_done;
	end
	k = cmd_ack;
	q = rd_data;
	#1;
	if (h)
		high_voltage_cmd_pin = 1'b0;
endtask
task automatic start;
	start_seen = 1'b1;
	@(posedge clock);
	#1;
	start_seen = 1'b0;
endtask
endmodule // dacwl_host

// File: tb/test_dacwl_register_write_lock.sv
// bench driving the lock block through its command port
`timescale 1ns/10ps
module test_dac_register_write_lock;
logic clock = 1'b0;
logic srst = 1'b1;
logic factory_init = 1'b1;
wire high_voltage_cmd_pin, start_seen, cmd_valid, cmd_ready, cmd_done;
wire cmd_ack, wait_start, bus_addr_lock_bit;
wire [1:0] cmd_op, output_gain_bit, value_lock_bit, config_lock_bit;
wire [4:0] cmd_addr;
wire [15:0] cmd_wdata, rd_data, dac0_code, dac1_code;
wire [3:0] ref_select_bits, powerdown_bits;
wire [6:0] stored_bus_addr_bits;
int mismatches = 0;
int n_checks = 0;
always #20 clock = ~clock;
dacwl_lock #(.NUM_CH(2), .RES(12)) dacwl_lock_i (.clock, .srst,
	.factory_init, .high_voltage_cmd_pin, .start_seen, .cmd_valid,
	.cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .cmd_done, .cmd_ack,
	.rd_data, .wait_start, .dac0_code, .dac1_code, .ref_select_bits,
	.powerdown_bits, .output_gain_bit, .stored_bus_addr_bits,
	.value_lock_bit, .config_lock_bit, .bus_addr_lock_bit);
dacwl_host dacwl_host_i (.clock, .cmd_ready, .cmd_done, .cmd_ack,
	.rd_data, .high_voltage_cmd_pin, .start_seen, .cmd_valid, .cmd_op,
	.cmd_addr, .cmd_wdata);
task automatic stop_test;
	if (mismatches == 0 && n_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
task automatic chk(input logic [15:0] g, input logic [15:0] e);
	n_checks++;
	if (g !== e) begin
		mismatches++;
		$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
	end
endtask
task automatic fail;
	mismatches++;
	$display("CHECK FAILED at %0t: no answer", $time);
	stop_test;
endtask
task automatic go(input logic h, input logic [1:0] o,
	input logic [4:0] a, input logic [15:0] w, input logic k,
	input logic [15:0] q);
	logic gk, ok;
	logic [15:0] gq;
	dacwl_host_i.cmd(h, o, a, w, gk, gq, ok);
	if (!ok)
		fail;
	chk({15'h0, gk}, {15'h0, k});
	chk(gq, q);
endtask
task automatic boot;
	int i;
	for (i = 0; i < 40 && cmd_ready !== 1'b1; i++)
		@(posedge clock);
	if (cmd_ready !== 1'b1)
		fail;
	#1;
endtask
initial begin
	repeat (2) @(posedge clock);
	#1;
	srst = 1'b0;
	factory_init = 1'b0;
	boot;
	chk(dac0_code, 16'h07ff);
	chk({4'h0, bus_addr_lock_bit, value_lock_bit, config_lock_bit,
		stored_bus_addr_bits}, 16'h0860);
	go(0, 2'h0, 5'h00, 16'hffff, 1, 16'h0);
	chk(dac0_code, 16'h0fff);
	go(0, 2'h0, 5'h10, 16'h0123, 1, 16'h0);
	go(0, 2'h1, 5'h10, 16'h0, 1, 16'h0123);
	go(0, 2'h2, 5'h10, 16'h0, 0, 16'hffff);
	chk({15'h0, wait_start}, 16'h1);
	go(0, 2'h0, 5'h00, 16'h0, 0, 16'hffff);
	dacwl_host_i.start;
	go(1, 2'h2, 5'h00, 16'h0, 1, 16'h0);
	chk({14'h0, config_lock_bit}, 16'h1);
	go(0, 2'h0, 5'h00, 16'h0456, 1, 16'h0);
	chk(dac0_code, 16'h0456);
	go(0, 2'h0, 5'h10, 16'h0789, 0, 16'hffff);
	dacwl_host_i.start;
	go(0, 2'h1, 5'h10, 16'h0, 1, 16'h0123);
	go(1, 2'h2, 5'h10, 16'h0, 1, 16'h0);
	chk({14'h0, value_lock_bit}, 16'h1);
	go(0, 2'h0, 5'h00, 16'h0abc, 0, 16'hffff);
	dacwl_host_i.start;
	chk(dac0_code, 16'h0456);
	go(0, 2'h0, 5'h09, 16'h000f, 1, 16'h0);
	chk({12'h0, powerdown_bits}, 16'h000c);
	go(1, 2'h3, 5'h00, 16'h0, 1, 16'h0);
	go(0, 2'h0, 5'h09, 16'h0003, 1, 16'h0);
	chk({12'h0, powerdown_bits}, 16'h0003);
	go(0, 2'h0, 5'h0a, 16'h0300, 1, 16'h0);
	chk({14'h0, output_gain_bit}, 16'h0003);
	go(0, 2'h1, 5'h0a, 16'h0, 1, 16'h0300);
	go(0, 2'h0, 5'h08, 16'h000a, 1, 16'h0);
	chk({12'h0, ref_select_bits}, 16'h000a);
	go(0, 2'h0, 5'h01, 16'hfabc, 1, 16'h0);
	chk(dac1_code, 16'h0abc);
	go(0, 2'h1, 5'h0b, 16'h0, 1, 16'h0002);
	dacwl_host_i.slow = 1'b1;
	go(0, 2'h1, 5'h02, 16'h0, 0, 16'hffff);
	dacwl_host_i.start;
	go(1, 2'h2, 5'h0a, 16'h0, 0, 16'hffff);
	dacwl_host_i.start;
	go(0, 2'h0, 5'h1a, 16'h0022, 1, 16'h0);
	go(0, 2'h1, 5'h1a, 16'h0, 1, 16'h00e0);
	go(1, 2'h3, 5'h1a, 16'h0, 1, 16'h0);
	chk({15'h0, bus_addr_lock_bit}, 16'h0);
	go(0, 2'h0, 5'h1a, 16'h0011, 1, 16'h0);
	srst = 1'b1;
	repeat (2) @(posedge clock);
	#1;
	srst = 1'b0;
	boot;
	chk({12'h0, value_lock_bit, config_lock_bit}, 16'h0004);
	chk(dac0_code, 16'h0123);
	chk(dac1_code, 16'h07ff);
	chk({10'h0, output_gain_bit, ref_select_bits}, 16'h0000);
	go(0, 2'h1, 5'h0a, 16'h0, 1, 16'h0080);
	chk({9'h0, stored_bus_addr_bits}, 16'h0011);
	stop_test;
end
endmodule // test_dac_register_write_lock
